// *** src/isf_formatter.sv ***
// Input sample formatter: fetches samples from local memory, scales them to 24-bit I/Q, pads with zeros.
// Assumes a one-cycle-latency synchronous read of 128-bit rows and a core that may stall via ready.

// Operation
// - 16-bit words shift left, extend upward
// - 32-bit words drop low bits, saturate
// - Signed mode sign-extends and saturates signed
// - Conjugate negates imaginary of complex samples
// - Real mode supplies zero imaginary part
// - Width select picks 16 or 32 bits
// - Pad zeros up to FFT length
// - Pad only while FFT enabled
// - Start address spans 64 KB byte space
// - Fetch count plus one samples per iteration
// - Advance address by sample stride
// - Next iteration starts iteration stride later
// - Run iteration count plus one iterations
// - One complex sample per clock steady state
module isf_formatter #(
    parameter int CNT_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mem_rd_o,
    output logic [isf_pkg::MEM_ADDR_W-1:0] mem_addr_o,
    input wire logic [isf_pkg::MEM_ROW_W-1:0] mem_rdata_i,
    output logic smp_valid_o,
    input wire logic smp_ready_i,
    output isf_pkg::isf_sample_s smp_data_o,
    output logic busy_o
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0] start_addr_ff;
    logic [CNT_W-1:0] smp_cnt_ff;
    logic [15:0] smp_stride_ff;
    logic [CNT_W-1:0] iter_cnt_ff;
    logic [15:0] iter_stride_ff;
    logic real_ff;
    logic width_ff;
    logic signed_ff;
    logic conj_ff;
    logic [7:0] shift_ff;
    logic [3:0] fft_log2_ff;
    logic fft_enable_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    isf_pkg::isf_state_e state_ff;

    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire bus_wr = bus_req & wb_we_i;
    wire sel_lo = wb_sel_i[0];
    wire wr_start = bus_wr & (wb_adr_i == isf_pkg::ADDR_START);
    wire wr_count = bus_wr & (wb_adr_i == isf_pkg::ADDR_COUNT);
    wire wr_sstr = bus_wr & (wb_adr_i == isf_pkg::ADDR_SSTRIDE);
    wire wr_icnt = bus_wr & (wb_adr_i == isf_pkg::ADDR_ITER_CNT);
    wire wr_istr = bus_wr & (wb_adr_i == isf_pkg::ADDR_ISTRIDE);
    wire wr_mode = bus_wr & (wb_adr_i == isf_pkg::ADDR_MODE) & sel_lo;
    wire wr_shift = bus_wr & (wb_adr_i == isf_pkg::ADDR_SHIFT) & sel_lo;
    wire wr_fft = bus_wr & (wb_adr_i == isf_pkg::ADDR_FFT) & sel_lo;
    wire wr_go = bus_wr & (wb_adr_i == isf_pkg::ADDR_CTRL) & sel_lo & wb_dat_i[isf_pkg::CTRL_START_BIT];
    wire is_busy = (state_ff != isf_pkg::ST_IDLE);

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (wb_adr_i == isf_pkg::ADDR_START) begin
            rd_mux[15:0] = start_addr_ff;
        end else if (wb_adr_i == isf_pkg::ADDR_COUNT) begin
            rd_mux[CNT_W-1:0] = smp_cnt_ff;
        end else if (wb_adr_i == isf_pkg::ADDR_SSTRIDE) begin
            rd_mux[15:0] = smp_stride_ff;
        end else if (wb_adr_i == isf_pkg::ADDR_ITER_CNT) begin
            rd_mux[CNT_W-1:0] = iter_cnt_ff;
        end else if (wb_adr_i == isf_pkg::ADDR_ISTRIDE) begin
            rd_mux[15:0] = iter_stride_ff;
        end else if (wb_adr_i == isf_pkg::ADDR_MODE) begin
            rd_mux[3:0] = {conj_ff, signed_ff, width_ff, real_ff};
        end else if (wb_adr_i == isf_pkg::ADDR_SHIFT) begin
            rd_mux[7:0] = shift_ff;
        end else if (wb_adr_i == isf_pkg::ADDR_FFT) begin
            rd_mux[4:0] = {fft_enable_ff, fft_log2_ff};
        end else if (wb_adr_i == isf_pkg::ADDR_STATUS) begin
            rd_mux[isf_pkg::STAT_BUSY_BIT] = is_busy;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            rdat_ff <= bus_req ? rd_mux : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // Configuration is frozen while a run is in progress
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_addr_ff <= isf_pkg::RST_ADDR;
            smp_cnt_ff <= CNT_W'(isf_pkg::RST_CNT);
            smp_stride_ff <= isf_pkg::RST_ADDR;
            iter_cnt_ff <= CNT_W'(isf_pkg::RST_CNT);
            iter_stride_ff <= isf_pkg::RST_ADDR;
            {conj_ff, signed_ff, width_ff, real_ff} <= 4'h0;
            shift_ff <= isf_pkg::RST_SHIFT;
            {fft_enable_ff, fft_log2_ff} <= 5'h00;
        end else if (!is_busy) begin
            if (wr_start) start_addr_ff <= merge16(start_addr_ff, wb_dat_i, wb_sel_i);
            if (wr_count) smp_cnt_ff <= CNT_W'(merge16(16'(smp_cnt_ff), wb_dat_i, wb_sel_i));
            if (wr_sstr) smp_stride_ff <= merge16(smp_stride_ff, wb_dat_i, wb_sel_i);
            if (wr_icnt) iter_cnt_ff <= CNT_W'(merge16(16'(iter_cnt_ff), wb_dat_i, wb_sel_i));
            if (wr_istr) iter_stride_ff <= merge16(iter_stride_ff, wb_dat_i, wb_sel_i);
            if (wr_mode) {conj_ff, signed_ff, width_ff, real_ff} <= wb_dat_i[3:0];
            if (wr_shift) shift_ff <= wb_dat_i[7:0];
            if (wr_fft) {fft_enable_ff, fft_log2_ff} <= wb_dat_i[4:0];
        end
    end

    // ****************************************************************
    // Address sequencer
    // ****************************************************************
    logic [15:0] iter_base_ff;
    logic [15:0] addr_ff;
    logic [CNT_W-1:0] smp_idx_ff;
    logic [CNT_W-1:0] iter_idx_ff;
    logic [15:0] pad_left_ff;
    logic rd_pend_ff;
    logic [3:0] rd_lane_ff;
    logic pad_pend_ff;
    logic buf_ready;

    // Total FFT length minus fetched count, zero when no padding applies
    wire [16:0] fft_len = 17'h00001 << fft_log2_ff;
    wire [16:0] fetched = 17'(smp_cnt_ff) + 17'h00001;
    wire pad_needed = fft_enable_ff & (fft_len > fetched);
    wire [15:0] pad_count = pad_needed ? 16'(fft_len - fetched) : 16'h0000;

    wire issue = (state_ff == isf_pkg::ST_FETCH) & buf_ready;
    wire pad_issue = (state_ff == isf_pkg::ST_PAD) & buf_ready;
    wire last_smp = (smp_idx_ff == smp_cnt_ff);
    wire last_iter = (iter_idx_ff == iter_cnt_ff);
    wire last_pad = (pad_left_ff == 16'h0001);
    wire [15:0] next_base = iter_base_ff + iter_stride_ff;

    isf_pkg::isf_state_e nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            isf_pkg::ST_IDLE: begin
                if (wr_go) nxt_state = isf_pkg::ST_FETCH;
            end
            isf_pkg::ST_FETCH: begin
                if (issue && last_smp) begin
                    if (pad_needed) nxt_state = isf_pkg::ST_PAD;
                    else if (last_iter) nxt_state = isf_pkg::ST_IDLE;
                end
            end
            isf_pkg::ST_PAD: begin
                if (pad_issue && last_pad) begin
                    nxt_state = last_iter ? isf_pkg::ST_IDLE : isf_pkg::ST_FETCH;
                end
            end
            default: nxt_state = isf_pkg::ST_IDLE;
        endcase
    end

    wire iter_done = (issue & last_smp & ~pad_needed) | (pad_issue & last_pad);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= isf_pkg::ST_IDLE;
            iter_base_ff <= isf_pkg::RST_ADDR;
            addr_ff <= isf_pkg::RST_ADDR;
            smp_idx_ff <= '0;
            iter_idx_ff <= '0;
            pad_left_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == isf_pkg::ST_IDLE) begin
                iter_base_ff <= start_addr_ff;
                addr_ff <= start_addr_ff;
                smp_idx_ff <= '0;
                iter_idx_ff <= '0;
            end else if (iter_done) begin
                iter_base_ff <= next_base;
                addr_ff <= next_base;
                smp_idx_ff <= '0;
                iter_idx_ff <= iter_idx_ff + CNT_W'(1);
            end else if (issue) begin
                addr_ff <= addr_ff + smp_stride_ff;
                smp_idx_ff <= smp_idx_ff + CNT_W'(1);
            end
            if (issue && last_smp) pad_left_ff <= pad_count;
            else if (pad_issue) pad_left_ff <= pad_left_ff - 16'h0001;
        end
    end

    assign mem_rd_o = issue;
    assign mem_addr_o = addr_ff;
    assign busy_o = is_busy;

    // One cycle of read latency; pad slots travel the same pipe to keep order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_pend_ff <= 1'b0;
            pad_pend_ff <= 1'b0;
            rd_lane_ff <= 4'h0;
        end else begin
            rd_pend_ff <= issue;
            pad_pend_ff <= pad_issue;
            rd_lane_ff <= addr_ff[isf_pkg::ROW_BYTES_LOG2-1:0];
        end
    end

    // ****************************************************************
    // Scaling and formatting
    // ****************************************************************
    wire [127:0] row_shift = mem_rdata_i >> ({3'h0, rd_lane_ff} * 7'(isf_pkg::BITS_PER_BYTE));
    wire [31:0] raw_re = width_ff ? row_shift[31:0] : {16'h0000, row_shift[15:0]};
    wire [31:0] raw_im = width_ff ? row_shift[63:32] : {16'h0000, row_shift[31:16]};
    wire [3:0] shamt = (shift_ff > isf_pkg::SHIFT_MAX) ? 4'(isf_pkg::SHIFT_MAX) : shift_ff[3:0];

    // Converts one component to 24 bits
    function automatic logic [23:0] scale(input logic [31:0] w, input logic wide, input logic sgn,
                                          input logic [3:0] sh);
        logic [47:0] ext;
        logic signed [47:0] val;
        logic [3:0] up;
        ext = '0;
        val = '0;
        up = 4'h8 - sh;
        if (!wide) begin
            ext = {{32{sgn & w[15]}}, w[15:0]};
            scale = 24'(ext << up);
        end else begin
            ext = {{16{sgn & w[31]}}, w[31:0]};
            val = $signed(ext) >>> sh;
            if (sgn) begin
                if (val > 48'sh7F_FFFF) scale = 24'h7F_FFFF;
                else if (val < -48'sh80_0000) scale = 24'h80_0000;
                else scale = val[23:0];
            end else begin
                scale = (val > 48'sh FF_FFFF) ? 24'hFF_FFFF : val[23:0];
            end
        end
    endfunction : scale

    wire [23:0] fmt_re = scale(raw_re, width_ff, signed_ff, shamt);
    wire [23:0] fmt_im0 = scale(raw_im, width_ff, signed_ff, shamt);
    wire [23:0] fmt_im = real_ff ? 24'h00_0000 : (conj_ff ? 24'(-fmt_im0) : fmt_im0);

    isf_pkg::isf_sample_s in_smp;
    assign in_smp.re = pad_pend_ff ? 24'h00_0000 : fmt_re;
    assign in_smp.im = pad_pend_ff ? 24'h00_0000 : fmt_im;
    wire in_valid = rd_pend_ff | pad_pend_ff;

    // ****************************************************************
    // Two-entry output buffer
    // ****************************************************************
    isf_pkg::isf_sample_s buf_ff [2];
    logic [1:0] cnt_ff;
    logic rp_ff;
    logic wp_ff;
    wire push = in_valid;
    wire pop = smp_valid_o & smp_ready_i;
    // Stall issue unless a slot is free even with one word still in the pipe
    assign buf_ready = (cnt_ff == 2'h0) | ((cnt_ff == 2'h1) & ~in_valid) | pop & (cnt_ff == 2'h1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 2'h0;
            rp_ff <= 1'b0;
            wp_ff <= 1'b0;
        end else begin
            if (push) wp_ff <= ~wp_ff;
            if (pop) rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) buf_ff[wp_ff] <= in_smp;
    end
    assign smp_valid_o = (cnt_ff != 2'h0);
    assign smp_data_o = buf_ff[rp_ff];

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_buf_bound: assert property (@(posedge clk_i) disable iff (rst_i) cnt_ff <= 2'h2)
        else $error("buffer overflow");
    chk_real_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (push && real_ff) |=> (buf_ff[$past(wp_ff)].im == 24'h00_0000))
        else $error("real mode imaginary not zero");
    chk_pad_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        pad_pend_ff |-> (in_smp.re == 24'h00_0000))
        else $error("pad sample not zero");
    chk_pad_fft: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == isf_pkg::ST_PAD) |-> fft_enable_ff)
        else $error("padding without fft enable");
    chk_stride_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (issue && !last_smp) |=> (addr_ff == $past(addr_ff) + $past(smp_stride_ff)))
        else $error("sample stride wrong");
    chk_iter_base: assert property (@(posedge clk_i) disable iff (rst_i)
        iter_done |=> (addr_ff == $past(iter_base_ff) + $past(iter_stride_ff)))
        else $error("iteration stride wrong");
    chk_go_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == isf_pkg::ST_IDLE && wr_go) |=> (addr_ff == $past(start_addr_ff)))
        else $error("start address wrong");
    chk_smp_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == isf_pkg::ST_FETCH) |-> (smp_idx_ff <= smp_cnt_ff))
        else $error("sample count overrun");
    chk_run_end: assert property (@(posedge clk_i) disable iff (rst_i)
        (iter_done && last_iter) |=> (state_ff == isf_pkg::ST_IDLE))
        else $error("run did not end");

    // Bus answer shape, stream hand-off, formatting, saturation and configuration
    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_rdat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data outside ack");
    chk_valid_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (smp_valid_o && !smp_ready_i) |=> (smp_valid_o && $stable(smp_data_o)))
        else $error("stalled sample not held");
    chk_full_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == isf_pkg::ST_FETCH && cnt_ff == 2'h0) |-> mem_rd_o)
        else $error("fetch stalled with empty buffer");
    chk_conj_neg: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_pend_ff && conj_ff && !real_ff) |-> ((in_smp.im + fmt_im0) == 24'h00_0000))
        else $error("conjugate not negated");
    chk_lsb_fill: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_pend_ff && !width_ff && shamt == 4'h0) |-> (fmt_re[7:0] == 8'h00))
        else $error("16-bit low bits not zero");
    chk_sat_signed: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_pend_ff && width_ff && signed_ff && shamt == 4'h0 && !raw_re[31] && raw_re[30:23] != 8'h00)
        |-> (fmt_re == 24'h7F_FFFF))
        else $error("signed saturation wrong");
    chk_sat_unsigned: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_pend_ff && width_ff && !signed_ff && shamt == 4'h0 && raw_re[31:24] != 8'h00) |-> (fmt_re == 24'hFF_FFFF))
        else $error("unsigned saturation wrong");
    chk_cfg_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        is_busy |=> ($stable(smp_cnt_ff) && $stable(start_addr_ff)))
        else $error("configuration changed while busy");
    chk_no_pad_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (issue && last_smp && !fft_enable_ff) |=> (state_ff != isf_pkg::ST_PAD))
        else $error("padding entered while fft disabled");

endmodule : isf_formatter

// *** src/isf_pkg.sv ***
// Package of the input sample formatter: register map, field layouts, states.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package isf_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_START = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_SSTRIDE = 8'h08;
    localparam logic [7:0] ADDR_ITER_CNT = 8'h0C;
    localparam logic [7:0] ADDR_ISTRIDE = 8'h10;
    localparam logic [7:0] ADDR_MODE = 8'h14;
    localparam logic [7:0] ADDR_SHIFT = 8'h18;
    localparam logic [7:0] ADDR_FFT = 8'h1C;
    localparam logic [7:0] ADDR_CTRL = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // Mode register fields
    localparam int MODE_REAL_BIT = 0;
    localparam int MODE_WIDTH_BIT = 1;
    localparam int MODE_SIGNED_BIT = 2;
    localparam int MODE_CONJ_BIT = 3;
    // FFT register fields
    localparam int FFT_ENABLE_BIT = 4;
    localparam int FFT_LOG2_MSB = 3;
    // Control and status fields
    localparam int CTRL_START_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;

    localparam int SAMPLE_W = 24;
    localparam int MEM_ROW_W = 128;
    localparam int MEM_ADDR_W = 16;
    localparam int ROW_BYTES_LOG2 = 4;
    localparam logic [4:0] BITS_PER_BYTE = 5'h08;
    localparam logic [7:0] SHIFT_MAX = 8'h08;

    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [11:0] RST_CNT = 12'h000;
    localparam logic [7:0] RST_SHIFT = 8'h00;

    typedef struct packed {
        logic [SAMPLE_W-1:0] re;
        logic [SAMPLE_W-1:0] im;
    } isf_sample_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_PAD = 3'b100
    } isf_state_e;

endpackage : isf_pkg

// *** verif/isf_mem_model.sv ***
// Local sample memory model: 128-bit rows, one-cycle read latency.
// Assumes byte addresses and a fixed byte pattern that the bench also reads.
module isf_mem_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    output logic [127:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [127:0] row;
    logic [127:0] held = 128'h0;

    function automatic logic [7:0] byte_at(input logic [15:0] a);
        return a[7:0] * 8'h9D + a[15:8] + 8'h11;
    endfunction : byte_at

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            row[8*i +: 8] = byte_at({addr_i[15:4], 4'h0} + 16'(i));
        end
    end

    // Cycles without a strobe show inverted data, so a late capture is caught
    always @(posedge clk_i) begin
        held <= rd_i ? row : ~held;
    end
    assign rdata_o = held;
endmodule : isf_mem_model

// *** verif/tb_input_sample_formatter.sv ***
// Testbench of the input sample formatter: register access and stream checks.
// Assumes isf_mem_model answers one cycle after each read strobe.
module tb_input_sample_formatter;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic rdy = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, junk;
    logic ack, mrd, vld, busy;
    logic [15:0] maddr;
    logic [127:0] mrow;
    isf_pkg::isf_sample_s smp;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    initial forever #50 clk_i = ~clk_i;

    isf_formatter dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mem_rd_o(mrd), .mem_addr_o(maddr), .mem_rdata_i(mrow), .smp_valid_o(vld),
        .smp_ready_i(rdy), .smp_data_o(smp), .busy_o(busy));
    isf_mem_model mem_u (.clk_i(clk_i), .rd_i(mrd), .addr_i(maddr), .rdata_o(mrow));

    // ****************************************************************
    // Checks and bus cycles
    // ****************************************************************
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_smp(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected sample at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_smp

    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d, junk);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0, q);
        check_word(q, exp);
    endtask : rd_chk

    function automatic logic [31:0] word(input logic [15:0] a);
        return {mem_u.byte_at(a + 16'h3), mem_u.byte_at(a + 16'h2), mem_u.byte_at(a + 16'h1), mem_u.byte_at(a)};
    endfunction : word

    function automatic logic [23:0] fmt(input logic [31:0] w, input logic wide, input logic sgn,
                                        input logic [7:0] sh);
        longint v;
        if (!wide) begin
            v = sgn ? longint'($signed(w[15:0])) : longint'(w[15:0]);
            return 24'(v <<< (8 - int'(sh)));
        end
        v = (sgn ? longint'($signed(w)) : longint'(w)) >>> int'(sh);
        if (sgn && v > 64'sh7FFFFF) return 24'h7FFFFF;
        if (sgn && v < -64'sh800000) return 24'h800000;
        if (!sgn && v > 64'shFFFFFF) return 24'hFFFFFF;
        return 24'(v);
    endfunction : fmt

    // ****************************************************************
    // One job: program, start, collect with stalls, compare
    // ****************************************************************
    // Source side only; phase modulation and circular shift never written
    task automatic run_job(input logic [15:0] st, ss, is, input logic [11:0] cnt, itc,
                           input logic [3:0] mode, input logic [7:0] sh, input logic [4:0] fft);
        logic [47:0] expq[$];
        logic [15:0] a;
        logic [23:0] ri;
        int n;
        int quiet;
        wr(isf_pkg::ADDR_START, {16'h0, st});
        wr(isf_pkg::ADDR_COUNT, {20'h0, cnt});
        wr(isf_pkg::ADDR_SSTRIDE, {16'h0, ss});
        wr(isf_pkg::ADDR_ITER_CNT, {20'h0, itc});
        wr(isf_pkg::ADDR_ISTRIDE, {16'h0, is});
        wr(isf_pkg::ADDR_MODE, {28'h0, mode});
        wr(isf_pkg::ADDR_SHIFT, {24'h0, sh});
        wr(isf_pkg::ADDR_FFT, {27'h0, fft});
        for (int i = 0; i <= int'(itc); i++) begin
            for (int k = 0; k <= int'(cnt); k++) begin
                a = st + 16'(i) * is + 16'(k) * ss;
                ri = mode[0] ? 24'h0 : fmt(word(a + (mode[1] ? 16'h4 : 16'h2)), mode[1], mode[2], sh);
                if (mode[3] && !mode[0]) ri = -ri;
                expq.push_back({fmt(word(a), mode[1], mode[2], sh), ri});
            end
            if (fft[4]) for (int k = int'(cnt) + 1; k < (1 << fft[3:0]); k++) expq.push_back(48'h0);
        end
        wr(isf_pkg::ADDR_CTRL, 32'h1);
        n = 0;
        quiet = 0;
        // Ends only after busy and valid stay low past the read pipe, so the last word is not lost
        do begin
            @(negedge clk_i);
            if (vld === 1'b1 && rdy === 1'b1) check_smp(smp, expq.size() ? expq.pop_front() : {48{1'bz}});
            n++;
            quiet = (busy === 1'b1 || vld === 1'b1) ? 0 : quiet + 1;
            @(posedge clk_i);
            rdy <= (n % 7 != 3) && (n % 11 < 8);
        end while (quiet < 4);
        check_word(32'(expq.size()), 32'h0);
        rd_chk(isf_pkg::ADDR_STATUS, 32'h0);
    endtask : run_job

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_regs;
        rd_chk(isf_pkg::ADDR_SSTRIDE, 32'h0);
        wr(isf_pkg::ADDR_START, 32'hFFFF_BEEF);
        rd_chk(isf_pkg::ADDR_START, 32'h0000_BEEF);
        sel <= 4'h1;
        wr(isf_pkg::ADDR_START, 32'h0000_5512);
        sel <= 4'h2;
        wr(isf_pkg::ADDR_MODE, 32'h0000_000F);
        sel <= 4'hF;
        rd_chk(isf_pkg::ADDR_START, 32'h0000_BE12);
        rd_chk(isf_pkg::ADDR_MODE, 32'h0);
        wr(isf_pkg::ADDR_COUNT, 32'hFFFF_FFFF);
        rd_chk(isf_pkg::ADDR_COUNT, 32'h0000_0FFF);
        wr(8'h3C, 32'h1234_5678);
        rd_chk(8'h3C, 32'h0);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_16bit;
        for (int s = 0; s < 2; s++) begin
            for (int sh = 0; sh <= 8; sh++) begin
                run_job(16'h0010, 16'h0004, 16'h0040, 12'h3, 12'h1, {1'b1, 1'(s), 2'b00}, 8'(sh), 5'h13);
            end
        end
        $display("test_16bit done");
    endtask : test_16bit

    task automatic test_32bit;
        for (int s = 0; s < 2; s++) begin
            for (int sh = 0; sh <= 8; sh += 4) begin
                run_job(16'h0000, 16'h0008, 16'h7FF8, 12'h1, 12'h2, {1'b0, 1'(s), 2'b10}, 8'(sh), 5'h04);
            end
        end
        $display("test_32bit done");
    endtask : test_32bit

    task automatic test_real;
        run_job(16'hC000, 16'h0010, 16'h0008, 12'h5, 12'h0, 4'b1101, 8'h02, 5'h13);
        $display("test_real done");
    endtask : test_real

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        test_regs();
        test_16bit();
        test_32bit();
        test_real();
        conclude();
    end
endmodule : tb_input_sample_formatter
